// >>> sdpc_pkg.sv
// Constants shared by the SYSREF divider and power control block
package sdpc_pkg;
    // ----------------------------------------
    // Register indices and byte addresses
    // ----------------------------------------
    localparam int SDPC_ADDR_W = 12;
    localparam logic [7:0] SDPC_IDX_CTRL = 8'h18;
    localparam logic [7:0] SDPC_IDX_IDLE = 8'h19;
    localparam logic [7:0] SDPC_IDX_STATUS = 8'h20;
    localparam logic [11:0] SDPC_ADDR_CTRL = {2'h0, SDPC_IDX_CTRL, 2'h0};
    localparam logic [11:0] SDPC_ADDR_IDLE = {2'h0, SDPC_IDX_IDLE, 2'h0};
    localparam logic [11:0] SDPC_ADDR_STATUS = {2'h0, SDPC_IDX_STATUS, 2'h0};

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int SDPC_PD_BIT = 7;
    localparam int SDPC_IDLE_BIT = 7;
    localparam int SDPC_DIV_TOP_BIT = 6;
    localparam int SDPC_DIV_MID_LSB = 4;
    localparam int SDPC_DIV_LOW_LSB = 2;
    localparam int SDPC_DIV_SMALL_LSB = 0;
    localparam int SDPC_STAT_PWR_BIT = 31;

    // ----------------------------------------
    // Reset values and widths
    // ----------------------------------------
    localparam logic SDPC_PD_RST = 1'b0;
    localparam logic [6:0] SDPC_DIV_RST = 7'h2F;
    localparam logic SDPC_IDLE_RST = 1'b1;
    localparam int SDPC_RATIO_W = 5;
    localparam int SDPC_TOTAL_W = 13;
    localparam logic [1:0] SDPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SDPC_RESP_SLVERR = 2'h2;
endpackage

// >>> sdpc_div_stage.sv
// One serial stage of the SYSREF frequency divider
`timescale 1ns/10ps
`default_nettype none
module sdpc_div_stage #(
    parameter int RATIO_W = 5
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear,
    input wire logic enable,
    input wire logic [RATIO_W-1:0] ratio,
    output logic tick
);
    logic [RATIO_W-1:0] count;
    logic [RATIO_W-1:0] next_count;
    logic at_end;

    // Using >= lets a ratio shrunk mid-count wrap at once
    assign at_end = (count >= ratio - RATIO_W'(1));
    assign tick = enable && at_end;

    always_comb begin
        next_count = count;
        if (clear) begin
            next_count = '0;
        end else if (enable) begin
            next_count = at_end ? '0 : count + RATIO_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
endmodule // sdpc_div_stage
`default_nettype wire

// >>> sdpc_top.sv
// SYSREF global power down, four-stage frequency divider and output idle select
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module sdpc_top #(
    parameter int NUM_OUTPUTS = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_OUTPUTS-1:0] output_bias_control,
    output logic sysref_div_tick,
    output logic sysref_blocks_enable,
    output logic [NUM_OUTPUTS-1:0] sysref_output_static,
    output logic [NUM_OUTPUTS-1:0] sysref_output_biased
);
    localparam int RW = sdpc_pkg::SDPC_RATIO_W;
    localparam int TW = sdpc_pkg::SDPC_TOTAL_W;

    if (NUM_OUTPUTS < 1 || NUM_OUTPUTS > 32) begin : g_bad_outputs
        $error("NUM_OUTPUTS must be 1 to 32");
    end

    // ----------------------------------------
    // Ratio decoding
    // ----------------------------------------
    function automatic logic [RW-1:0] sdpc_pow2_ratio(input logic [1:0] code);
        return RW'(2) << code;
    endfunction

    function automatic logic [RW-1:0] sdpc_small_ratio(input logic [1:0] code);
        return RW'(code) + RW'(2);
    endfunction

    // ----------------------------------------
    // Register file and AXI4-Lite slave
    // ----------------------------------------
    logic pd, next_pd;
    logic [6:0] sysref_freq_divider, next_sysref_freq_divider;
    logic idle_sel, next_idle_sel;
    logic [11:0] aw_addr, next_aw_addr;
    logic aw_held, next_aw_held;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic w_held, next_w_held;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [1:0] rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic enable_q, next_enable_q;
    logic div_written;
    logic [RW-1:0] ratio [4];
    logic [TW-1:0] total_ratio;

    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready = !w_held && !bvalid;
    assign s_axi_arready = !rvalid;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rresp = rresp;
    assign s_axi_rdata = rdata;
    assign sysref_blocks_enable = enable_q;

    always_comb begin
        next_pd = pd;
        next_sysref_freq_divider = sysref_freq_divider;
        next_idle_sel = idle_sel;
        next_aw_addr = aw_addr;
        next_aw_held = aw_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_w_held = w_held;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        div_written = 1'b0;
        // Power state mirrors the bit one cycle later
        next_enable_q = !pd;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_addr = s_axi_awaddr;
            next_aw_held = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
            next_w_held = 1'b1;
        end
        if (aw_held && w_held && !bvalid) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = sdpc_pkg::SDPC_RESP_OKAY;
            if (aw_addr == sdpc_pkg::SDPC_ADDR_CTRL) begin
                if (w_strb[0]) begin
                    next_pd = w_data[sdpc_pkg::SDPC_PD_BIT];
                    next_sysref_freq_divider = w_data[6:0];
                    div_written = 1'b1;
                end
            end else if (aw_addr == sdpc_pkg::SDPC_ADDR_IDLE) begin
                if (w_strb[0]) begin
                    next_idle_sel = w_data[sdpc_pkg::SDPC_IDLE_BIT];
                end
            end else if (aw_addr != sdpc_pkg::SDPC_ADDR_STATUS) begin
                next_bresp = sdpc_pkg::SDPC_RESP_SLVERR;
            end
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = sdpc_pkg::SDPC_RESP_OKAY;
            next_rdata = '0;
            if (s_axi_araddr == sdpc_pkg::SDPC_ADDR_CTRL) begin
                next_rdata[7:0] = {pd, sysref_freq_divider};
            end else if (s_axi_araddr == sdpc_pkg::SDPC_ADDR_IDLE) begin
                next_rdata[sdpc_pkg::SDPC_IDLE_BIT] = idle_sel;
            end else if (s_axi_araddr == sdpc_pkg::SDPC_ADDR_STATUS) begin
                next_rdata[TW-1:0] = total_ratio;
                next_rdata[sdpc_pkg::SDPC_STAT_PWR_BIT] = enable_q;
            end else begin
                next_rresp = sdpc_pkg::SDPC_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pd <= sdpc_pkg::SDPC_PD_RST;
            sysref_freq_divider <= sdpc_pkg::SDPC_DIV_RST;
            idle_sel <= sdpc_pkg::SDPC_IDLE_RST;
            aw_addr <= '0;
            aw_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            w_held <= 1'b0;
            bvalid <= 1'b0;
            bresp <= sdpc_pkg::SDPC_RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= sdpc_pkg::SDPC_RESP_OKAY;
            rdata <= '0;
            enable_q <= 1'b0;
        end else begin
            pd <= next_pd;
            sysref_freq_divider <= next_sysref_freq_divider;
            idle_sel <= next_idle_sel;
            aw_addr <= next_aw_addr;
            aw_held <= next_aw_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            w_held <= next_w_held;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            enable_q <= next_enable_q;
        end
    end

    // ----------------------------------------
    // Four serial divider stages
    // ----------------------------------------
    logic [4:0] stage_en;
    logic [3:0] stage_tick;
    logic next_div_tick;

    assign ratio[0] = sdpc_small_ratio(
        sysref_freq_divider[sdpc_pkg::SDPC_DIV_SMALL_LSB +: 2]);
    assign ratio[1] = sdpc_pow2_ratio(
        sysref_freq_divider[sdpc_pkg::SDPC_DIV_LOW_LSB +: 2]);
    assign ratio[2] = sdpc_pow2_ratio(
        sysref_freq_divider[sdpc_pkg::SDPC_DIV_MID_LSB +: 2]);
    assign ratio[3] = sdpc_pow2_ratio(
        {1'b0, sysref_freq_divider[sdpc_pkg::SDPC_DIV_TOP_BIT]});
    assign total_ratio = TW'(ratio[0]) * TW'(ratio[1]) * TW'(ratio[2]) * TW'(ratio[3]);
    // Power down holds every stage cleared and idle
    assign stage_en[0] = !pd;

    for (genvar i = 0; i < 4; i++) begin : g_stage
        sdpc_div_stage #(.RATIO_W(RW)) u_stage (
            .aclk(aclk),
            .aresetn(aresetn),
            .clear(pd || div_written),
            .enable(stage_en[i]),
            .ratio(ratio[i]),
            .tick(stage_tick[i])
        );
        // Each stage after the first counts only the wraps of the one before
        assign stage_en[i+1] = stage_tick[i];
    end

    assign next_div_tick = stage_en[4] && !pd;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sysref_div_tick <= 1'b0;
        end else begin
            sysref_div_tick <= next_div_tick;
        end
    end

    // ----------------------------------------
    // Output idle state select
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sysref_output_static <= '0;
            sysref_output_biased <= '0;
        end else begin
            sysref_output_static <= output_bias_control & {NUM_OUTPUTS{!idle_sel}};
            sysref_output_biased <= output_bias_control & {NUM_OUTPUTS{idle_sel}};
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [TW-1:0] gap;
    logic armed;

    // Gap between output pulses, valid only while settings stay put
    always_ff @(posedge aclk) begin
        if (!aresetn || pd || div_written) begin
            gap <= '0;
            armed <= 1'b0;
        end else if (sysref_div_tick) begin
            gap <= TW'(1);
            armed <= 1'b1;
        end else begin
            gap <= gap + TW'(1);
        end
    end

    sequence s_pd_write;
        aw_held && w_held && !bvalid && aw_addr == sdpc_pkg::SDPC_ADDR_CTRL && w_strb[0];
    endsequence

    pd_stops_tick_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pd |=> !sysref_div_tick) else $error("divider pulse while powered down");
    pd_drops_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_pd_write ##1 pd |=> !sysref_blocks_enable) else $error("enable held in power down");
    up_keeps_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !pd [*2] |-> sysref_blocks_enable) else $error("blocks not enabled when powered");
    period_product_a: assert property (@(posedge aclk) disable iff (!aresetn)
        armed && sysref_div_tick |-> gap == total_ratio) else $error("pulse period wrong");
    top_stage_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ratio[3] == (sysref_freq_divider[6] ? RW'(4) : RW'(2))) else $error("top stage ratio");
    mid_stage_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sysref_freq_divider[5:4] == 2'h3 |-> ratio[2] == RW'(16)) else $error("mid stage ratio");
    low_stage_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sysref_freq_divider[3:2] == 2'h2 |-> ratio[1] == RW'(8)) else $error("low stage ratio");
    small_stage_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sysref_freq_divider[1:0] == 2'h1 |-> ratio[0] == RW'(3)) else $error("small stage ratio");
    idle_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 sysref_output_biased == ($past(output_bias_control) &
        {NUM_OUTPUTS{$past(idle_sel)}})) else $error("idle state wrong");
    reset_ratio_a: assert property (@(posedge aclk)
        $past(!aresetn) && aresetn |-> sysref_freq_divider == 7'h2F && total_ratio == TW'(1280))
        else $error("divider reset value wrong");
endmodule // sdpc_top
`default_nettype wire

// >>> sdpc_top_tb.sv
// Self-checking testbench for the SYSREF divider and power control block
`timescale 1ns/10ps
`default_nettype none
module sdpc_top_tb;
    // ----------------------------------------
    // Clock, reset and ports
    // ----------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0, bias = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, tick, blk_en;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] out_static, out_biased;
    int bad_count = 0;
    int n_tests = 0;
    logic [1:0] resp;
    logic [31:0] data;
    int period;
    logic [6:0] codes [13] = '{7'h2F, 7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h08, 7'h0C,
        7'h10, 7'h20, 7'h30, 7'h40, 7'h7F};

    always #10 aclk = ~aclk;

    sdpc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .output_bias_control(bias), .sysref_div_tick(tick),
        .sysref_blocks_enable(blk_en), .sysref_output_static(out_static),
        .sysref_output_biased(out_biased));

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic hang(input string what);
        bad_count++;
        $display("ERROR %s expected answer seen none", what);
        wrap_up();
    endtask

    // ----------------------------------------
    // AXI4-Lite master
    // ----------------------------------------
    // Readies are combinational, so they are sampled at the falling edge
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_hit, w_hit, b_hit;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(negedge aclk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            b_hit = bvalid;
            r = bresp;
            @(posedge aclk);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
            if (b_hit) begin
                bready <= 1'b0;
                return;
            end
        end
        hang("write response");
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hit;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(negedge aclk);
            ar_hit = arvalid && arready;
            d = rdata;
            r = rresp;
            if (rvalid) begin
                @(posedge aclk);
                rready <= 1'b0;
                arvalid <= 1'b0;
                return;
            end
            @(posedge aclk);
            if (ar_hit) arvalid <= 1'b0;
        end
        hang("read response");
    endtask

    // Cycles between two consecutive divider ticks
    task automatic measure(output int n);
        int i;
        for (i = 0; i < 6000 && tick !== 1'b1; i++) @(negedge aclk);
        if (i == 6000) hang("first tick");
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (tick !== 1'b1 && n < 6000);
        if (tick !== 1'b1) hang("next tick");
    endtask

    function automatic logic [31:0] ratio(input logic [6:0] c);
        return (32'(c[1:0]) + 32'h2) * (32'h2 << c[3:2]) * (32'h2 << c[5:4])
            * (c[6] ? 32'h4 : 32'h2);
    endfunction

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(sdpc_pkg::SDPC_ADDR_CTRL, data, resp);
        check("ctrl reset", data, 32'h0000_002F);
        axi_read(sdpc_pkg::SDPC_ADDR_IDLE, data, resp);
        check("idle reset", data, 32'h0000_0080);
        axi_read(sdpc_pkg::SDPC_ADDR_STATUS, data, resp);
        check("status reset", data, 32'h8000_0500);
        check("enable after reset", 32'(blk_en), 32'h1);
        axi_read(12'h0FC, data, resp);
        check("unmapped read resp", 32'(resp), 32'h2);
        axi_write(12'h0FC, 32'h0000_00FF, resp);
        check("unmapped write resp", 32'(resp), 32'h2);
        $display("test reset_and_map done");

        // Every code of every stage, plus the reset code first
        foreach (codes[k]) begin
            if (k > 0) axi_write(sdpc_pkg::SDPC_ADDR_CTRL, 32'(codes[k]), resp);
            measure(period);
            check("tick period", 32'(period), ratio(codes[k]));
        end
        $display("test divider_ratios done");

        axi_write(sdpc_pkg::SDPC_ADDR_CTRL, 32'h0000_0080, resp);
        repeat (2) @(negedge aclk);
        check("enable in power down", 32'(blk_en), 32'h0);
        for (int i = 0; i < 200; i++) begin
            @(negedge aclk);
            if (tick !== 1'b0) check("tick in power down", 32'(tick), 32'h0);
        end
        axi_read(sdpc_pkg::SDPC_ADDR_STATUS, data, resp);
        check("status in power down", data, 32'h0000_0010);
        axi_write(sdpc_pkg::SDPC_ADDR_CTRL, 32'h0000_0000, resp);
        measure(period);
        check("period after power up", 32'(period), 32'h10);
        check("enable after power up", 32'(blk_en), 32'h1);
        $display("test power_down done");

        @(posedge aclk);
        bias <= 4'hA;
        repeat (3) @(negedge aclk);
        check("biased idle", 32'(out_biased), 32'hA);
        check("static idle off", 32'(out_static), 32'h0);
        axi_write(sdpc_pkg::SDPC_ADDR_IDLE, 32'h0000_0000, resp);
        repeat (3) @(negedge aclk);
        check("static idle", 32'(out_static), 32'hA);
        check("biased idle off", 32'(out_biased), 32'h0);
        $display("test idle_select done");
        wrap_up();
    end
endmodule // sdpc_top_tb
`default_nettype wire
